// File: rtl/flsr_pkg.sv
package flsr_pkg;

    // Register word offsets (byte addresses)
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h08;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;

    // Status word field positions
    localparam int BIT_READY = 0;
    localparam int BIT_ROM_TYPE = 2;
    localparam int PROT_LSB = 4;
    localparam int NUM_BLOCKS = 4;
    localparam int BLK_W = 2;

    // Event bits shared by interrupt status, clear and enable
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_LOST = 2;
    localparam int EV_REFUSED = 3;
    localparam int NUM_EV = 4;

    // Command byte that returns the array to read mode
    localparam logic [7:0] CMD_READ_RESET = 8'hF0;

    // Reset values
    localparam logic READY_RST = 1'b1;
    localparam logic [NUM_EV-1:0] IRQ_ENABLE_RST = 4'h0;

    // Program request from the command sequencer
    typedef struct packed {
        logic valid;
        logic [BLK_W-1:0] block;
    } flsr_prog_req_t;

    // Whole state of the status block
    typedef struct packed {
        logic op_done_flag;
        logic failed;
        logic cmd_blocked;
        logic mask_rom;
        logic strap_taken;
        logic [NUM_EV-1:0] irq_status;
        logic [NUM_EV-1:0] irq_enable;
        logic [31:0] rdata;
    } flsr_state_t;

    localparam flsr_state_t STATE_RST = '{
        op_done_flag: READY_RST,
        failed: 1'b0,
        cmd_blocked: 1'b0,
        mask_rom: 1'b0,
        strap_taken: 1'b0,
        irq_status: 4'h0,
        irq_enable: IRQ_ENABLE_RST,
        rdata: 32'h0000_0000
    };

endpackage : flsr_pkg

// File: rtl/flsr_prot_gate.sv
`timescale 1ns/100ps
`default_nettype none

module flsr_prot_gate #(
    parameter int NUM_BLOCKS = flsr_pkg::NUM_BLOCKS
) (
    input wire flsr_pkg::flsr_prog_req_t req_i,
    input wire logic [NUM_BLOCKS-1:0] prot_i,
    input wire logic ready_i,
    output logic go_o,
    output logic refused_o
);

    logic [NUM_BLOCKS-1:0] hit;

    // Per-block match of a program request against its protection bit
    for (genvar g = 0; g < NUM_BLOCKS; g++) begin : g_blk
        assign hit[g] = req_i.valid && (req_i.block == (flsr_pkg::BLK_W)'(g)) && prot_i[g];
    end

    // Protected blocks are refused; others start only when ready
    assign refused_o = |hit;
    assign go_o = req_i.valid && !refused_o && ready_i;

endmodule : flsr_prot_gate

`default_nettype wire

// File: rtl/flsr_status.sv
// Function
// - Ready flag reads 0 while an automatic program or erase runs.
// - Ready flag returns to 1 once the automatic operation ends cleanly.
// - A failed automatic operation keeps the ready flag at 0.
// - Hardware reset forces the ready flag back to 1.
// - Command while busy may be lost and block input; reset recovers.
// - Status bit 2 shows ROM type: 0 flash, 1 mask ROM.
// - Status bits 7..4 show each block's protection, any combination.
// - Programming a protected block is refused and leaves it unchanged.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module flsr_status #(
    parameter int NUM_BLOCKS = flsr_pkg::NUM_BLOCKS
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic auto_active_i,
    input wire logic auto_fail_i,
    input wire logic [NUM_BLOCKS-1:0] prot_state_i,
    input wire logic rom_mask_strap_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_accept_o,
    output logic cmd_blocked_o,
    input wire flsr_pkg::flsr_prog_req_t prog_req_i,
    output logic prog_go_o,
    output logic prog_refused_o,
    output logic op_done_flag_o,
    output logic irq_o
);

    flsr_pkg::flsr_state_t st;
    flsr_pkg::flsr_state_t next_st;
    logic reset_cmd;
    logic busy_cmd;
    logic [flsr_pkg::NUM_EV-1:0] events;
    logic [31:0] status_word;

    // Program requests checked against block protection
    flsr_prot_gate #(
        .NUM_BLOCKS(NUM_BLOCKS)
    ) u_gate (
        .req_i(prog_req_i),
        .prot_i(prot_state_i),
        .ready_i(st.op_done_flag && !st.cmd_blocked),
        .go_o(prog_go_o),
        .refused_o(prog_refused_o)
    );

    // Status word assembly, undefined positions held at zero
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[flsr_pkg::BIT_READY] = st.op_done_flag;
        status_word[flsr_pkg::BIT_ROM_TYPE] = st.mask_rom;
        status_word[flsr_pkg::PROT_LSB +: NUM_BLOCKS] = prot_state_i;
    end

    // Next-state logic for the whole block
    always_comb begin
        next_st = st;
        reset_cmd = cmd_wr_i && (cmd_data_i == flsr_pkg::CMD_READ_RESET);
        busy_cmd = cmd_wr_i && !reset_cmd && !st.op_done_flag;
        events = '0;

        // ROM type strap caught once after reset release
        if (!st.strap_taken) begin
            next_st.mask_rom = rom_mask_strap_i;
            next_st.strap_taken = 1'b1;
        end

        // Failure is sticky until the read/reset command; a new failure wins
        if (reset_cmd) begin
            next_st.failed = 1'b0;
        end
        if (auto_fail_i) begin
            next_st.failed = 1'b1;
        end

        // Command while busy jams further command input
        if (reset_cmd) begin
            next_st.cmd_blocked = 1'b0;
        end
        if (busy_cmd) begin
            next_st.cmd_blocked = 1'b1;
        end

        // Ready flag: low while running or after a failure
        next_st.op_done_flag = !auto_active_i && !next_st.failed;

        // Event detection
        events[flsr_pkg::EV_DONE] = !st.op_done_flag && next_st.op_done_flag;
        events[flsr_pkg::EV_FAIL] = auto_fail_i && !st.failed;
        events[flsr_pkg::EV_LOST] = busy_cmd;
        events[flsr_pkg::EV_REFUSED] = prog_refused_o;

        // Interrupt status: clear first so a same-cycle event survives
        if (reg_wr_i && reg_addr_i == flsr_pkg::OFS_IRQ_CLEAR) begin
            next_st.irq_status = st.irq_status & ~reg_wdata_i[flsr_pkg::NUM_EV-1:0];
        end
        next_st.irq_status = next_st.irq_status | events;

        // Interrupt enable write
        if (reg_wr_i && reg_addr_i == flsr_pkg::OFS_IRQ_ENABLE) begin
            next_st.irq_enable = reg_wdata_i[flsr_pkg::NUM_EV-1:0];
        end

        // Read data stands only in the cycle after the strobe
        next_st.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                flsr_pkg::OFS_STATUS: next_st.rdata = status_word;
                flsr_pkg::OFS_IRQ_STATUS: begin
                    next_st.rdata[flsr_pkg::NUM_EV-1:0] = st.irq_status;
                end
                flsr_pkg::OFS_IRQ_ENABLE: begin
                    next_st.rdata[flsr_pkg::NUM_EV-1:0] = st.irq_enable;
                end
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register, synchronous reset
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st <= flsr_pkg::STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign reg_rdata_o = st.rdata;
    assign op_done_flag_o = st.op_done_flag;
    assign cmd_blocked_o = st.cmd_blocked;
    assign cmd_accept_o = cmd_wr_i && (reset_cmd || (st.op_done_flag && !st.cmd_blocked));
    assign irq_o = |(st.irq_status & st.irq_enable);

    // Busy while an automatic operation runs
    property p_busy_low;
        @(posedge core_clk_i) disable iff (reset_i)
        auto_active_i |=> !op_done_flag_o;
    endproperty
    a_busy_low: assert property (p_busy_low)
        else $error("ready flag high during automatic operation");

    // Clean end returns to ready in one cycle
    property p_ready_after_done;
        @(posedge core_clk_i) disable iff (reset_i)
        (!auto_active_i && !auto_fail_i && !st.failed) |=> op_done_flag_o;
    endproperty
    a_ready_after_done: assert property (p_ready_after_done)
        else $error("ready flag not restored after clean end");

    // Failure keeps busy until a read/reset command
    property p_fail_sticky;
        @(posedge core_clk_i) disable iff (reset_i)
        (auto_fail_i ##1 (!reset_cmd) [*3]) |-> !op_done_flag_o;
    endproperty
    a_fail_sticky: assert property (p_fail_sticky)
        else $error("ready flag rose after a failure");

    // First cycle after reset shows ready
    property p_reset_ready;
        @(posedge core_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> (op_done_flag_o && !st.failed && !cmd_blocked_o);
    endproperty
    a_reset_ready: assert property (p_reset_ready)
        else $error("ready flag not one after reset");

    // Command while busy blocks input until a reset command
    property p_busy_cmd_blocks;
        @(posedge core_clk_i) disable iff (reset_i)
        (cmd_wr_i && !reset_cmd && !op_done_flag_o) |=>
            (cmd_blocked_o && st.irq_status[flsr_pkg::EV_LOST]);
    endproperty
    a_busy_cmd_blocks: assert property (p_busy_cmd_blocks)
        else $error("busy command did not block input");

    // Reset command always accepted and unblocks
    property p_reset_cmd_recovers;
        @(posedge core_clk_i) disable iff (reset_i)
        (reset_cmd && !auto_fail_i) |-> cmd_accept_o ##1 (!cmd_blocked_o && !st.failed);
    endproperty
    a_reset_cmd_recovers: assert property (p_reset_cmd_recovers)
        else $error("read/reset command did not recover");

    // ROM type bit in a status read
    property p_rom_type_read;
        @(posedge core_clk_i) disable iff (reset_i)
        (reg_rd_i && reg_addr_i == flsr_pkg::OFS_STATUS) |=>
            (reg_rdata_o[flsr_pkg::BIT_ROM_TYPE] == $past(st.mask_rom));
    endproperty
    a_rom_type_read: assert property (p_rom_type_read)
        else $error("ROM type bit wrong in status read");

    // Protection bits in a status read
    property p_prot_read;
        @(posedge core_clk_i) disable iff (reset_i)
        (reg_rd_i && reg_addr_i == flsr_pkg::OFS_STATUS) |=>
            (reg_rdata_o[flsr_pkg::PROT_LSB +: NUM_BLOCKS] == $past(prot_state_i));
    endproperty
    a_prot_read: assert property (p_prot_read)
        else $error("protection bits wrong in status read");

    // No program start on a protected block
    property p_prot_refuse;
        @(posedge core_clk_i) disable iff (reset_i)
        (prog_req_i.valid && prot_state_i[prog_req_i.block]) |->
            (!prog_go_o && prog_refused_o) ##1 st.irq_status[flsr_pkg::EV_REFUSED];
    endproperty
    a_prot_refuse: assert property (p_prot_refuse)
        else $error("program allowed on protected block");

    // Undefined status bits read zero, ready bit follows flag
    property p_status_reserved;
        @(posedge core_clk_i) disable iff (reset_i)
        (reg_rd_i && reg_addr_i == flsr_pkg::OFS_STATUS) |=>
            (reg_rdata_o[31:8] == 24'h000000 && !reg_rdata_o[1] && !reg_rdata_o[3]
             && reg_rdata_o[flsr_pkg::BIT_READY] == $past(op_done_flag_o));
    endproperty
    a_status_reserved: assert property (p_status_reserved)
        else $error("reserved status bits not zero");

    // Read data idle when no read was made
    property p_rdata_idle;
        @(posedge core_clk_i) disable iff (reset_i)
        !reg_rd_i |=> (reg_rdata_o == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data present without read");

    // A failure beside a read/reset command still leaves the flag low
    property p_fail_wins_reset;
        @(posedge core_clk_i) disable iff (reset_i)
        (auto_fail_i && reset_cmd) |=> !op_done_flag_o;
    endproperty
    a_fail_wins_reset: assert property (p_fail_wins_reset)
        else $error("read/reset command cleared a same-cycle failure");

    // Jammed input stays jammed until a read/reset command
    property p_blocked_holds;
        @(posedge core_clk_i) disable iff (reset_i)
        (cmd_blocked_o && !reset_cmd) |=> cmd_blocked_o;
    endproperty
    a_blocked_holds: assert property (p_blocked_holds)
        else $error("command input unjammed without recovery");

    // Jammed input accepts nothing but the read/reset command
    property p_blocked_refuses;
        @(posedge core_clk_i) disable iff (reset_i)
        (cmd_blocked_o && cmd_wr_i && !reset_cmd) |-> !cmd_accept_o;
    endproperty
    a_blocked_refuses: assert property (p_blocked_refuses)
        else $error("command accepted while input jammed");

    // Ready and unjammed means the next command is taken
    property p_ready_accepts;
        @(posedge core_clk_i) disable iff (reset_i)
        (cmd_wr_i && op_done_flag_o && !cmd_blocked_o) |-> cmd_accept_o;
    endproperty
    a_ready_accepts: assert property (p_ready_accepts)
        else $error("command refused while ready");

    // Program start only when ready, unjammed and unprotected
    property p_go_needs_ready;
        @(posedge core_clk_i) disable iff (reset_i)
        prog_go_o |-> (op_done_flag_o && !cmd_blocked_o && !prog_refused_o);
    endproperty
    a_go_needs_ready: assert property (p_go_needs_ready)
        else $error("program started while busy or jammed");

    // Refusal only for a request aimed at a protected block
    property p_refused_only_protected;
        @(posedge core_clk_i) disable iff (reset_i)
        prog_refused_o |->
            (prog_req_i.valid && prot_state_i[prog_req_i.block]);
    endproperty
    a_refused_only_protected: assert property (p_refused_only_protected)
        else $error("program refused on a free block");

    // ROM type holds once caught
    property p_rom_type_stable;
        @(posedge core_clk_i) disable iff (reset_i)
        st.strap_taken |=> $stable(st.mask_rom);
    endproperty
    a_rom_type_stable: assert property (p_rom_type_stable)
        else $error("ROM type bit changed after capture");

    // Event bits stay set until software clears them
    property p_event_sticky;
        @(posedge core_clk_i) disable iff (reset_i)
        !(reg_wr_i && reg_addr_i == flsr_pkg::OFS_IRQ_CLEAR) |=>
            ((st.irq_status & $past(st.irq_status)) == $past(st.irq_status));
    endproperty
    a_event_sticky: assert property (p_event_sticky)
        else $error("event bit dropped without a clear");

    // A new event survives a clear in the same cycle
    property p_set_wins;
        @(posedge core_clk_i) disable iff (reset_i)
        (events != '0) |=>
            ((st.irq_status & $past(events)) == $past(events));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost to a same-cycle clear");

    // Event bits in an interrupt status read
    property p_irq_status_read;
        @(posedge core_clk_i) disable iff (reset_i)
        (reg_rd_i && reg_addr_i == flsr_pkg::OFS_IRQ_STATUS) |=>
            (reg_rdata_o[flsr_pkg::NUM_EV-1:0] == $past(st.irq_status)
             && reg_rdata_o[31:flsr_pkg::NUM_EV] == '0);
    endproperty
    a_irq_status_read: assert property (p_irq_status_read)
        else $error("interrupt status read wrong");

    // Flag low, nothing running, no failure pending: ready next cycle with event
    property p_done_event;
        @(posedge core_clk_i) disable iff (reset_i)
        (!op_done_flag_o && !auto_active_i && !auto_fail_i && (!st.failed || reset_cmd))
            |=> (op_done_flag_o && st.irq_status[flsr_pkg::EV_DONE]);
    endproperty
    a_done_event: assert property (p_done_event)
        else $error("ready flag or done event missing at end");

    // Enable register takes the written value
    property p_enable_write;
        @(posedge core_clk_i) disable iff (reset_i)
        (reg_wr_i && reg_addr_i == flsr_pkg::OFS_IRQ_ENABLE) |=>
            (st.irq_enable == $past(reg_wdata_i[flsr_pkg::NUM_EV-1:0]));
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("interrupt enable write lost");

    // Read/reset command with nothing running brings back ready
    property p_ready_reset_cmd;
        @(posedge core_clk_i) disable iff (reset_i)
        (reset_cmd && !auto_fail_i && !auto_active_i) |=> op_done_flag_o;
    endproperty
    a_ready_reset_cmd: assert property (p_ready_reset_cmd)
        else $error("read/reset command did not restore ready");

endmodule : flsr_status

`default_nettype wire

// File: bench/flsr_testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic auto_active_i = 1'b0;
    logic auto_fail_i = 1'b0;
    logic [3:0] prot_state_i = 4'hA;
    logic rom_mask_strap_i = 1'b1;
    logic cmd_wr_i = 1'b0;
    logic [7:0] cmd_data_i = 8'h00;
    logic cmd_accept_o, cmd_blocked_o, prog_go_o, prog_refused_o, op_done_flag_o, irq_o;
    flsr_pkg::flsr_prog_req_t prog_req_i = '0;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] rd;

    // Clock at 250 MHz
    always #2 core_clk_i = ~core_clk_i;

    flsr_status DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .auto_active_i(auto_active_i), .auto_fail_i(auto_fail_i),
        .prot_state_i(prot_state_i), .rom_mask_strap_i(rom_mask_strap_i),
        .cmd_wr_i(cmd_wr_i), .cmd_data_i(cmd_data_i), .cmd_accept_o(cmd_accept_o),
        .cmd_blocked_o(cmd_blocked_o), .prog_req_i(prog_req_i), .prog_go_o(prog_go_o),
        .prog_refused_o(prog_refused_o), .op_done_flag_o(op_done_flag_o), .irq_o(irq_o));

    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick

    // One-cycle read, data taken in the following cycle
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask : reg_read

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : reg_write

    // Command byte pulse, acceptance seen in the same cycle
    task automatic send_cmd(input logic [7:0] c, input logic exp_acc);
        @(posedge core_clk_i);
        cmd_wr_i <= 1'b1;
        cmd_data_i <= c;
        #1;
        chk(cmd_accept_o, exp_acc);
        @(posedge core_clk_i);
        cmd_wr_i <= 1'b0;
        #1;
    endtask : send_cmd

    // Status word after reset: ready, strap, protection, zero elsewhere
    task automatic test_reset_status;
        chk(op_done_flag_o, 1'b1);
        reg_read(flsr_pkg::OFS_STATUS, rd);
        chk(rd, 32'h0000_00A5);
        reg_write(flsr_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        prot_state_i <= 4'h6;
        reg_read(flsr_pkg::OFS_STATUS, rd);
        chk(rd, 32'h0000_0065);
        @(posedge core_clk_i);
        prot_state_i <= 4'hA;
        reg_read(8'hFC, rd);
        chk(rd, 32'h0000_0000);
    endtask : test_reset_status

    // Busy while active, ready again after a clean end
    task automatic test_busy;
        @(posedge core_clk_i);
        auto_active_i <= 1'b1;
        tick(1);
        chk(op_done_flag_o, 1'b0);
        tick(5);
        chk(op_done_flag_o, 1'b0);
        @(posedge core_clk_i);
        auto_active_i <= 1'b0;
        tick(1);
        chk(op_done_flag_o, 1'b1);
    endtask : test_busy

    // Program gate against protected and free blocks
    task automatic test_prog;
        @(posedge core_clk_i);
        prog_req_i <= '{valid: 1'b1, block: 2'h1};
        #1;
        chk({prog_go_o, prog_refused_o}, 2'h1);
        @(posedge core_clk_i);
        prog_req_i <= '{valid: 1'b1, block: 2'h0};
        #1;
        chk({prog_go_o, prog_refused_o}, 2'h2);
        @(posedge core_clk_i);
        prog_req_i <= '0;
    endtask : test_prog

    // Sticky events, enable, clear
    task automatic test_irq;
        reg_read(flsr_pkg::OFS_IRQ_STATUS, rd);
        chk(rd, 32'h0000_0009);
        chk(irq_o, 1'b0);
        reg_write(flsr_pkg::OFS_IRQ_ENABLE, 32'h0000_0008);
        tick(1);
        chk(irq_o, 1'b1);
        reg_write(flsr_pkg::OFS_IRQ_CLEAR, 32'h0000_0008);
        tick(1);
        chk(irq_o, 1'b0);
        reg_read(flsr_pkg::OFS_IRQ_STATUS, rd);
        chk(rd, 32'h0000_0001);
    endtask : test_irq

    // Failure keeps busy, lost command jams input, recovery paths
    task automatic test_fail;
        @(posedge core_clk_i);
        auto_active_i <= 1'b1;
        auto_fail_i <= 1'b1;
        @(posedge core_clk_i);
        auto_active_i <= 1'b0;
        auto_fail_i <= 1'b0;
        tick(4);
        chk(op_done_flag_o, 1'b0);
        send_cmd(8'hA0, 1'b0);
        chk(cmd_blocked_o, 1'b1);
        send_cmd(8'h90, 1'b0);
        send_cmd(flsr_pkg::CMD_READ_RESET, 1'b1);
        chk({cmd_blocked_o, op_done_flag_o}, 2'h1);
        // Ready seen, so a normal command goes through
        send_cmd(8'hA0, 1'b1);
        @(posedge core_clk_i);
        auto_fail_i <= 1'b1;
        @(posedge core_clk_i);
        auto_fail_i <= 1'b0;
        tick(2);
        chk(op_done_flag_o, 1'b0);
        send_cmd(8'hA0, 1'b0);
        reg_read(flsr_pkg::OFS_IRQ_STATUS, rd);
        chk(rd, 32'h0000_0007);
        reg_read(flsr_pkg::OFS_IRQ_ENABLE, rd);
        chk(rd, 32'h0000_0008);
        // Mid-run system reset, held two edges, with the flash strap
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        rom_mask_strap_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        tick(1);
        chk({cmd_blocked_o, op_done_flag_o}, 2'h1);
        chk(irq_o, 1'b0);
        reg_read(flsr_pkg::OFS_STATUS, rd);
        chk(rd, 32'h0000_00A1);
    endtask : test_fail

    // Hang guard
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        tick(1);
        test_reset_status();
        test_busy();
        test_prog();
        test_irq();
        test_fail();
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
